/* File: logic/acts_top.sv */
// Conversion timing sequencer with APB registers and per-channel results.
`timescale 1ns/100ps
module acts_top
    import acts_pkg::*;
#(
    parameter int SLEEP_UNIT_CYC = SLEEP_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   bus_addr_select_pin,
    input  wire logic signed [RAW_W-1:0] conv_raw,
    output logic                        int_b,
    output logic                        ext_amp_power_ctl,
    output logic                        selector_to_ground,
    output logic [1:0]                  selector_channel,
    output logic                        sample_connect,
    output logic                        converting
);
    acts_phase_t         phase_q;
    logic [3:0]          mode_q;
    logic [1:0]          ch_q;
    logic [1:0]          scan_cnt_q;
    logic [CNT_W-1:0]    cnt_q;
    logic                pu_needed_q;
    logic [31:0]         timing_q;
    logic [2:0]          config_q;
    logic                event_q;
    logic [RES_W-1:0]    data_q [NUM_CH];
    logic                sel_meta_q;
    logic                sel_sync_q;
    logic [RES_W-1:0]    clip_code;
    logic                wr_acc;
    logic                rd_acc;
    logic                mode_wr;
    logic                status_rd;
    logic                conv_end;
    logic [CNT_W-1:0]    pu_len;
    logic [CNT_W-1:0]    acq_len;
    logic [CNT_W-1:0]    slp_len;
    logic                scan_mode;
    logic                last_of_scan;
    logic [31:0]         rd_word;
    logic                rd_ok;

    // The clipped code is taken in the last convert cycle, when the word
    // from the analog side has settled.
    acts_clip u_clip (
        .raw  (conv_raw),
        .code (clip_code)
    );

    // A write lands at the edge where the master samples pready high, so a
    // stalled transfer never changes a register. A read is looked up one
    // edge earlier, in its first access cycle, so that the registered read
    // data stands together with pready.
    assign wr_acc    = psel & penable & pwrite & pready;
    assign rd_acc    = psel & penable & ~pwrite & ~pready;
    assign mode_wr   = wr_acc & (paddr == ADDR_MODE);
    assign status_rd = rd_acc & (paddr == ADDR_STATUS);
    assign conv_end  = (phase_q == PH_CONVERT) && (cnt_q == '0);

    // Interval lengths in clock cycles, each loaded as length minus one.
    // Limitation: the sleep unit times sixty-four must fit in CNT_W bits,
    // or the longest times-eight sleep wraps to a short one.
    always_comb begin
        logic [CNT_W-1:0] base;
        base    = CNT_W'(SLEEP_UNIT_CYC)
                  * CNT_W'(timing_q[SLP_LSB +: 3] + 4'h1);
        pu_len  = CNT_W'(timing_q[PU_LSB +: 5]) * CNT_W'(STEP_CYC);
        acq_len = CNT_W'(timing_q[ACQ_LSB +: 5]) * CNT_W'(STEP_CYC)
                  + CNT_W'(ACQ_MIN_CYC);
        if (timing_q[MULT8_BIT]) begin
            slp_len = base << 3;
        end else if (timing_q[DIV4_BIT]) begin
            slp_len = base >> 2;
        end else begin
            slp_len = base;
        end
    end

    // Scan modes step the channel after every conversion and wrap from the
    // last channel back to channel 0.
    assign scan_mode = (mode_q == MODE_MSCAN) || (mode_q == MODE_ASCAN)
                       || (mode_q == MODE_ASCAN_S)
                       || (mode_q == MODE_BURST_S);
    assign last_of_scan = (scan_cnt_q == 2'(NUM_CH - 1));

    // Address select pin comes from outside and is synchronised first.
    // The first flip-flop may settle late, so only the second is read.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_meta_q <= 1'b0;
            sel_sync_q <= 1'b0;
        end else begin
            sel_meta_q <= bus_addr_select_pin;
            sel_sync_q <= sel_meta_q;
        end
    end

    // Timing fields are read again at each phase start, so a timing write
    // in mid-phase only changes the phases that begin after it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timing_q <= TIMING_RST;
            config_q <= CONFIG_RST;
        end else if (wr_acc && paddr == ADDR_TIMING) begin
            timing_q <= pwdata;
        end else if (wr_acc && paddr == ADDR_CONFIG) begin
            config_q <= pwdata[2:0];
        end
    end

    // Sequencer: every interval is counted on the internal clock.
    // A mode write wins over the running count, so it restarts the sequence
    // at once and cuts short whatever phase was in progress.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q     <= PH_IDLE;
            mode_q      <= MODE_IDLE;
            ch_q        <= 2'h0;
            scan_cnt_q  <= 2'h0;
            cnt_q       <= '0;
            pu_needed_q <= 1'b1;
        end else if (mode_wr) begin
            mode_q     <= pwdata[MODE_LSB +: 4];
            ch_q       <= pwdata[CHSEL_LSB +: 2];
            scan_cnt_q <= 2'h0;
            case (pwdata[MODE_LSB +: 4])
                MODE_IDLE: begin
                    phase_q     <= PH_IDLE;
                    pu_needed_q <= 1'b1;
                end
                MODE_AWAKE: begin
                    phase_q <= PH_AWAKE;
                end
                default: begin
                    // Power-up only after a stay in idle.
                    if (pu_needed_q && pu_len != '0) begin
                        phase_q <= PH_POWERUP;
                        cnt_q   <= pu_len - 1'b1;
                    end else begin
                        phase_q <= PH_ACQUIRE;
                        cnt_q   <= acq_len - 1'b1;
                    end
                    pu_needed_q <= 1'b0;
                end
            endcase
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end else begin
            case (phase_q)
                PH_POWERUP: begin
                    phase_q <= PH_ACQUIRE;
                    cnt_q   <= acq_len - 1'b1;
                end
                PH_ACQUIRE: begin
                    phase_q <= PH_CONVERT;
                    cnt_q   <= CNT_W'(CONV_CYC - 1);
                end
                PH_CONVERT: begin
                    if (scan_mode) begin
                        ch_q       <= ch_q + 2'h1;
                        scan_cnt_q <= scan_cnt_q + 2'h1;
                    end
                    case (mode_q)
                        MODE_MSINGLE: begin
                            phase_q <= PH_AWAKE;
                        end
                        MODE_MSCAN: begin
                            phase_q <= last_of_scan ? PH_AWAKE
                                                    : PH_ACQUIRE;
                            cnt_q   <= acq_len - 1'b1;
                        end
                        MODE_ASINGLE_S, MODE_ASCAN_S: begin
                            phase_q <= PH_SLEEP;
                            cnt_q   <= slp_len - 1'b1;
                        end
                        MODE_BURST_S: begin
                            if (last_of_scan) begin
                                phase_q <= PH_SLEEP;
                                cnt_q   <= slp_len - 1'b1;
                            end else begin
                                phase_q <= PH_ACQUIRE;
                                cnt_q   <= acq_len - 1'b1;
                            end
                        end
                        default: begin
                            phase_q <= PH_ACQUIRE;
                            cnt_q   <= acq_len - 1'b1;
                        end
                    endcase
                end
                PH_SLEEP: begin
                    phase_q <= PH_ACQUIRE;
                    cnt_q   <= acq_len - 1'b1;
                end
                default: begin
                    phase_q <= phase_q;
                end
            endcase
        end
    end

    // Each channel owns its result word; results land with no latency.
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_data
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    data_q[i] <= '0;
                end else if (conv_end && ch_q == 2'(i)) begin
                    data_q[i] <= clip_code;
                end
            end
        end
    endgenerate

    // A finishing conversion wins over a status read in the same cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            event_q <= 1'b0;
        end else if (conv_end) begin
            event_q <= 1'b1;
        end else if (status_rd) begin
            event_q <= 1'b0;
        end
    end

    // Pins follow the phase one cycle late; the trade keeps every pin
    // glitch free, straight from a flip-flop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_b              <= 1'b1;
            ext_amp_power_ctl  <= 1'b0;
            selector_to_ground <= 1'b0;
            selector_channel   <= 2'h0;
            sample_connect     <= 1'b0;
            converting         <= 1'b0;
        end else begin
            int_b <= ~(event_q & config_q[INTEN_BIT]);
            ext_amp_power_ctl <= config_q[PWREN_BIT]
                                 && phase_q != PH_IDLE
                                 && phase_q != PH_SLEEP;
            selector_to_ground <= config_q[MUXGND_BIT];
            selector_channel   <= ch_q;
            sample_connect     <= (phase_q == PH_ACQUIRE);
            converting         <= (phase_q == PH_CONVERT);
        end
    end

    // Read lookup: an unknown offset returns zero and flags an error.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (paddr)
            ADDR_MODE: begin
                rd_word[MODE_LSB +: 4]  = mode_q;
                rd_word[CHSEL_LSB +: 2] = ch_q;
            end
            ADDR_TIMING: begin
                rd_word = timing_q;
            end
            ADDR_CONFIG: begin
                rd_word[2:0] = config_q;
            end
            ADDR_STATUS: begin
                rd_word[BUSY_BIT]  = (phase_q != PH_IDLE)
                                     && (phase_q != PH_AWAKE);
                rd_word[EVENT_BIT] = event_q;
                rd_word[CURCH_LSB +: 2] = ch_q;
                rd_word[SADDR_LSB +: 7] = SER_ADDR_BASE
                                          | {6'h00, sel_sync_q};
            end
            default: begin
                if (paddr[7:4] == ADDR_DATA0[7:4] && paddr[1:0] == 2'h0) begin
                    rd_word[RES_W-1:0] = data_q[paddr[3:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // One wait state keeps every bus output straight from a flip-flop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= rd_acc ? (rd_ok ? rd_word : 32'h0000_0000)
                              : 32'h0000_0000;
            pslverr <= psel & penable & ~pready & ~rd_ok;
        end
    end
endmodule

/* File: logic/acts_pkg.sv */
// Shared constants, modes and phases of the conversion timing sequencer.
package acts_pkg;
    localparam int CLK_HZ        = 25_000_000;
    localparam int T_STEP_US     = 2;
    localparam int T_ACQ_MIN_US  = 6;
    localparam int T_CONV_US     = 4;
    localparam int T_SLEEP_US    = 1000;
    localparam int STEP_CYC      = T_STEP_US * (CLK_HZ / 1_000_000);
    localparam int ACQ_MIN_CYC   = T_ACQ_MIN_US * (CLK_HZ / 1_000_000);
    localparam int CONV_CYC      = T_CONV_US * (CLK_HZ / 1_000_000);
    localparam int SLEEP_CYC     = T_SLEEP_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W         = 24;
    localparam int RES_W         = 12;
    localparam int RAW_W         = 14;
    localparam int NUM_CH        = 4;

    localparam logic [7:0] ADDR_MODE   = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_DATA0  = 8'h10;

    localparam int MODE_LSB   = 0;
    localparam int CHSEL_LSB  = 4;
    localparam int PU_LSB     = 0;
    localparam int ACQ_LSB    = 8;
    localparam int SLP_LSB    = 16;
    localparam int MULT8_BIT  = 20;
    localparam int DIV4_BIT   = 21;
    localparam int PWREN_BIT  = 0;
    localparam int MUXGND_BIT = 1;
    localparam int INTEN_BIT  = 2;
    localparam int BUSY_BIT   = 0;
    localparam int EVENT_BIT  = 1;
    localparam int CURCH_LSB  = 4;
    localparam int SADDR_LSB  = 8;

    localparam logic [31:0] TIMING_RST = 32'h0000_0000;
    localparam logic [2:0]  CONFIG_RST = 3'h0;
    localparam logic [6:0]  SER_ADDR_BASE = 7'h48;

    localparam logic [3:0] MODE_IDLE     = 4'h0;
    localparam logic [3:0] MODE_AWAKE    = 4'h1;
    localparam logic [3:0] MODE_MSINGLE  = 4'h2;
    localparam logic [3:0] MODE_MSCAN    = 4'h3;
    localparam logic [3:0] MODE_ASINGLE  = 4'h4;
    localparam logic [3:0] MODE_ASCAN    = 4'h5;
    localparam logic [3:0] MODE_ASINGLE_S = 4'h6;
    localparam logic [3:0] MODE_ASCAN_S  = 4'h7;
    localparam logic [3:0] MODE_BURST_S  = 4'h8;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_AWAKE,
        PH_POWERUP,
        PH_ACQUIRE,
        PH_CONVERT,
        PH_SLEEP
    } acts_phase_t;
endpackage

/* File: logic/acts_clip.sv */
// Saturating reduction of the raw converter word to a 12-bit code.
`timescale 1ns/100ps
module acts_clip
    import acts_pkg::*;
#(
    parameter int IN_W  = RAW_W,
    parameter int OUT_W = RES_W
) (
    input  wire logic signed [IN_W-1:0] raw,
    output logic        [OUT_W-1:0]     code
);
    localparam logic signed [IN_W-1:0] FULL =
        IN_W'((1 << OUT_W) - 1);

    // Out-of-range inputs hold at the end codes instead of wrapping.
    always_comb begin
        if (raw < 0) begin
            code = '0;
        end else if (raw > FULL) begin
            code = '1;
        end else begin
            code = OUT_W'(raw);
        end
    end
endmodule

/* File: verification/acts_checker.sv */
// Port-level assertions for the conversion timing sequencer.
`timescale 1ns/100ps
module acts_checker
    import acts_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        int_b,
    input wire logic        ext_amp_power_ctl,
    input wire logic        sample_connect,
    input wire logic        converting
);
    logic [4:0]  acq_q;
    logic        pwr_q, inten_q, abort_q, sc_q, wr_ok, unmapped;
    logic [11:0] acq_cnt_q, conv_cnt_q;
    assign wr_ok = pready && pwrite && !pslverr;
    assign unmapped = paddr[1:0] != 2'h0 || paddr > 8'h1C;
    // Shadows load at the same write edge as the design's registers; the
    // pins follow one cycle later, so enables are checked one cycle back.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acq_q <= 5'h0;
            pwr_q <= 1'h0;
            inten_q <= 1'h0;
        end else if (wr_ok && paddr == ADDR_TIMING) begin
            acq_q <= pwdata[ACQ_LSB +: 5];
        end else if (wr_ok && paddr == ADDR_CONFIG) begin
            pwr_q <= pwdata[PWREN_BIT];
            inten_q <= pwdata[INTEN_BIT];
        end
    end
    // A mode write cuts a phase short, so that phase is not measured.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acq_cnt_q <= 12'h0;
            conv_cnt_q <= 12'h0;
            sc_q <= 1'h0;
            abort_q <= 1'h0;
        end else begin
            acq_cnt_q <= sample_connect ? acq_cnt_q + 12'h1 : 12'h0;
            conv_cnt_q <= converting ? conv_cnt_q + 12'h1 : 12'h0;
            sc_q <= sample_connect;
            if (wr_ok && paddr == ADDR_MODE) begin
                abort_q <= 1'h1;
            end else if (sample_connect && !sc_q) begin
                abort_q <= 1'h0;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_ready_next: assert property (
        psel && penable && !pready |=> pready) else $error("no pready");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_slverr_map: assert property (pready |-> pslverr == unmapped)
        else $error("pslverr wrong");
    a_data_width: assert property (
        pready && !pwrite && paddr >= ADDR_DATA0 && !unmapped
        |-> prdata[31:12] == 20'h0) else $error("result too wide");
    a_acq_length: assert property (
        $fell(sample_connect) && !abort_q
        |-> acq_cnt_q == 12'(ACQ_MIN_CYC + STEP_CYC * acq_q))
        else $error("acquisition length wrong");
    a_conv_length: assert property (
        $fell(converting) && !abort_q |-> conv_cnt_q == 12'(CONV_CYC))
        else $error("conversion length wrong");
    a_acq_first: assert property (
        $rose(converting) |-> $past(sample_connect))
        else $error("conversion without acquisition");
    a_cap_open: assert property (!(sample_connect && converting))
        else $error("capacitor closed while converting");
    a_int_enabled: assert property (
        !int_b |-> $past(inten_q))
        else $error("interrupt while disabled");
    a_amp_enabled: assert property (
        ext_amp_power_ctl |-> $past(pwr_q))
        else $error("amplifier on while disabled");
    c_conv_done: cover property ($fell(converting));
    c_slverr: cover property (pready && pslverr);
    c_int: cover property ($fell(int_b));
endmodule
bind acts_top acts_checker chk_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .int_b(int_b),
    .ext_amp_power_ctl(ext_amp_power_ctl),
    .sample_connect(sample_connect), .converting(converting));

/* File: verification/acts_afe_model.sv */
// Analog front end model: holds the tracked input as the converter word.
`timescale 1ns/100ps
module acts_afe_model
    import acts_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic [1:0]                   selector_channel,
    input  wire logic                         selector_to_ground,
    input  wire logic                         sample_connect,
    input  wire logic [NUM_CH-1:0][RAW_W-1:0] lvl,
    output logic signed [RAW_W-1:0]           conv_raw
);
    logic signed [RAW_W-1:0] held_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held_q <= '0;
        end else if (sample_connect) begin
            held_q <= selector_to_ground ? '0 : lvl[selector_channel];
        end
    end
    // While tracking there is no settled word, so show a wrong one.
    assign conv_raw = sample_connect ? ~held_q : held_q;
endmodule

/* File: verification/test_acts_top.sv */
// Register-level test of the conversion timing sequencer.
`timescale 1ns/100ps
module test_acts_top
    import acts_pkg::*;
;
    localparam logic [31:0] EXPD [NUM_CH] = '{32'hFFF, 32'h0, 32'h123, 32'hFFF};
    localparam logic [3:0] MDS [7] = '{MODE_ASINGLE, MODE_ASINGLE_S,
        MODE_ASINGLE_S, MODE_ASINGLE_S, MODE_ASCAN, MODE_ASCAN_S, MODE_BURST_S};
    localparam logic [31:0] TMG [7] = '{32'h30000, 32'h30000, 32'h130000,
        32'h230000, 32'h30000, 32'h30000, 32'h30000};
    localparam int SLP [7] = '{0, 32, 256, 8, 0, 32, 0};
    logic                         clk = 1'h0;
    logic                         rst_b, psel, penable, pwrite, pready, er;
    logic                         pslverr, int_b, amp, gnd, sc, cv, asel;
    logic [7:0]                   paddr;
    logic [31:0]                  pwdata, prdata, rdv;
    logic [1:0]                   sch;
    logic signed [RAW_W-1:0]      raw;
    logic [NUM_CH-1:0][RAW_W-1:0] lvl;
    int                           err_count = 0, checks_done = 0, n, d1, d2;
    always #20 clk = ~clk;
    acts_top #(.SLEEP_UNIT_CYC(8)) dut_u (.clk(clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .bus_addr_select_pin(asel), .conv_raw(raw), .int_b(int_b),
        .ext_amp_power_ctl(amp), .selector_to_ground(gnd),
        .selector_channel(sch), .sample_connect(sc), .converting(cv));
    acts_afe_model afe_u (.clk(clk), .rst_b(rst_b), .selector_channel(sch),
        .selector_to_ground(gnd), .sample_connect(sc), .lvl(lvl),
        .conv_raw(raw));
    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        // Only the watchdog ends a wait for pready.
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rdv = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wait_v(input bit on_cv, input logic v, output int c);
        c = 0;
        while ((on_cv ? cv : sc) !== v) begin
            @(posedge clk);
            c++;
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        end_of_test;
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        asel = 1'h1;
        lvl = {14'hFFF, 14'h123, 14'h3FFD, 14'h1388};
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        chk("int_b", int_b, 1'h1);
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped_err", er, 1'h1);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("status", rdv, {17'h0, SER_ADDR_BASE | 7'h01, 8'h0});
        asel <= 1'h0;
        repeat (3) @(posedge clk);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("status_sel_low", rdv, {17'h0, SER_ADDR_BASE, 8'h0});
        $display("test reset done");
        apb(1'h1, ADDR_CONFIG, 32'h5);
        apb(1'h1, ADDR_TIMING, 32'h101);
        apb(1'h1, ADDR_MODE, 32'(MODE_MSCAN));
        repeat (4) begin
            wait_v(1'h1, 1'h1, n);
            wait_v(1'h1, 1'h0, n);
        end
        repeat (3) @(posedge clk);
        chk("int_b", int_b, 1'h0);
        for (int i = 0; i < NUM_CH; i++) begin
            apb(1'h0, ADDR_DATA0 + 8'(4 * i), 32'h0);
            chk("data", rdv, EXPD[i]);
        end
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("event", rdv[EVENT_BIT], 1'h1);
        chk("int_b", int_b, 1'h1);
        apb(1'h1, ADDR_MODE, 32'(MODE_AWAKE));
        chk("amp_on", amp, 1'h1);
        apb(1'h1, ADDR_MODE, 32'(MODE_IDLE));
        @(posedge clk);
        chk("amp_off", amp, 1'h0);
        $display("test scan done");
        apb(1'h1, ADDR_CONFIG, 32'h3);
        apb(1'h1, ADDR_TIMING, 32'h3);
        apb(1'h1, ADDR_MODE, 32'h20 | 32'(MODE_MSINGLE));
        wait_v(1'h0, 1'h1, d1);
        wait_v(1'h1, 1'h1, n);
        wait_v(1'h1, 1'h0, n);
        chk("ground", gnd, 1'h1);
        repeat (3) @(posedge clk);
        apb(1'h0, ADDR_DATA0 + 8'h8, 32'h0);
        chk("ground_data", rdv, 32'h0);
        apb(1'h1, ADDR_MODE, 32'h20 | 32'(MODE_MSINGLE));
        wait_v(1'h0, 1'h1, d2);
        chk("pu_skip", d1 - d2, 3 * STEP_CYC);
        wait_v(1'h1, 1'h1, n);
        wait_v(1'h1, 1'h0, n);
        apb(1'h1, ADDR_TIMING, 32'h0);
        apb(1'h1, ADDR_MODE, 32'(MODE_IDLE));
        apb(1'h1, ADDR_MODE, 32'h20 | 32'(MODE_MSINGLE));
        wait_v(1'h0, 1'h1, n);
        chk("pu_zero", n, d2);
        $display("test power-up done");
        apb(1'h1, ADDR_CONFIG, 32'h5);
        for (int i = 0; i < 7; i++) begin
            apb(1'h1, ADDR_TIMING, TMG[i]);
            apb(1'h1, ADDR_MODE, 32'(MDS[i]));
            wait_v(1'h1, 1'h1, n);
            wait_v(1'h1, 1'h0, n);
            wait_v(1'h0, 1'h1, n);
            if (i == 0) d1 = n;
            chk("sleep_gap", n - d1, SLP[i]);
        end
        $display("test sleep done");
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        chk("rst_amp", amp, 1'h0);
        chk("rst_int", int_b, 1'h1);
        rst_b <= 1'h1;
        @(posedge clk);
        apb(1'h0, ADDR_DATA0, 32'h0);
        chk("rst_data", rdv, 32'h0);
        apb(1'h1, ADDR_MODE, 32'(MODE_MSINGLE));
        wait_v(1'h0, 1'h1, n);
        chk("amp_disabled", amp, 1'h0);
        wait_v(1'h1, 1'h1, n);
        wait_v(1'h1, 1'h0, n);
        apb(1'h0, ADDR_DATA0, 32'h0);
        chk("rst_rerun", rdv, 32'hFFF);
        $display("test mid-run reset done");
        end_of_test;
    end
endmodule
